// file: pkg/pio_pkg.sv
// package of constants and types for the programmed i/o bus engine
package pio_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] REG_INSTR = 8'h00;
	localparam logic [7:0] REG_ACC = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_LIGHTS = 8'h0c;
	localparam logic [7:0] REG_SWITCH = 8'h10;
	localparam int ST_BUSY = 0;
	localparam int ST_SKIP = 1;
	localparam int ST_ACTED = 2;
	localparam int ST_NOTIO = 3;
	localparam logic [15:0] ACC_RST = 16'h0000;
	localparam logic [15:0] LIGHTS_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// instruction encoding
	localparam logic [3:0] IO_PATTERN = 4'hc;
	localparam logic [1:0] TYPE_OCP = 2'h0;
	localparam logic [1:0] TYPE_SKS = 2'h1;
	localparam logic [1:0] TYPE_INA = 2'h2;
	localparam logic [1:0] TYPE_OTA = 2'h3;
	localparam logic [5:0] DEV_PANEL = 6'h10;
	// ==========================================================
	// timing: cycles the bus address stands before the answer is sampled
	localparam logic [2:0] SETTLE_CYCLES = 3'h4;
	// ==========================================================
	// types
	typedef struct packed {
		logic [1:0] kind;
		logic [3:0] pattern;
		logic [3:0] func;
		logic [5:0] dev;
	} pio_instr_t;
	typedef struct packed {
		logic [1:0] kind;
		logic [3:0] func;
		logic [5:0] dev;
	} pio_bus_cmd_t;
	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_SEL = 4'h2,
		S_TEST = 4'h4,
		S_PULSE = 4'h8
	} pio_state_t;
endpackage : pio_pkg

// file: rtl/pio_sync.sv
// two flip-flop synchroniser for bus pins
`timescale 1ns/100ps
module pio_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta;

	// meta feeds only the second stage
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			meta <= '0;
			q_out <= '0;
		end else begin
			meta <= d_in;
			q_out <= meta;
		end
	end
endmodule : pio_sync

// file: rtl/pio_decode.sv
// field decoder for i/o class instructions
`timescale 1ns/100ps
module pio_decode (
	input wire pio_pkg::pio_instr_t instr_in,
	output logic is_io_out,
	output logic is_panel_out
);
	// ==========================================================
	// class and device checks
	assign is_io_out = (instr_in.pattern == pio_pkg::IO_PATTERN);
	assign is_panel_out = (instr_in.dev == pio_pkg::DEV_PANEL);
endmodule : pio_decode

// file: rtl/pio_engine.sv
// programmed i/o engine: axi4-lite slave and i/o bus sequencer
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module pio_engine (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output pio_pkg::pio_bus_cmd_t io_cmd_out,
	output logic io_select_out,
	output logic io_strobe_out,
	output logic [15:0] io_data_out,
	input wire logic io_present_in,
	input wire logic io_ready_in,
	input wire logic io_need_ready_in,
	input wire logic [15:0] io_data_in,
	input wire logic [15:0] io_data_mask_in,
	input wire logic [15:0] panel_switch_in,
	output logic [15:0] panel_lights_out
);
	// ==========================================================
	// declarations
	pio_pkg::pio_state_t state;
	pio_pkg::pio_instr_t cur;
	pio_pkg::pio_instr_t wr_instr;
	logic [2:0] settle;
	logic [15:0] acc;
	logic skip_flag;
	logic acted_flag;
	logic notio_flag;
	logic aw_full;
	logic w_full;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic start;
	logic new_is_io;
	logic cur_is_panel;
	logic s_present;
	logic s_ready;
	logic s_need;
	logic [15:0] s_data;
	logic [15:0] s_mask;
	logic [15:0] s_switch;
	logic t_act;
	logic t_skip;
	logic t_pulse;
	logic [31:0] rd_word;
	logic rd_err;

	// ==========================================================
	// pin synchronisers
	pio_sync #(
		.W(51)
	) u_sync (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.d_in({io_present_in, io_ready_in, io_need_ready_in,
			io_data_in, io_data_mask_in, panel_switch_in}),
		.q_out({s_present, s_ready, s_need, s_data, s_mask, s_switch})
	);

	// ==========================================================
	// decoders
	assign wr_instr = pio_pkg::pio_instr_t'(w_data[15:0]);

	pio_decode u_dec_new (
		.instr_in(wr_instr),
		.is_io_out(new_is_io),
		.is_panel_out()
	);

	pio_decode u_dec_cur (
		.instr_in(cur),
		.is_io_out(),
		.is_panel_out(cur_is_panel)
	);

	// ==========================================================
	// axi4-lite write path
	assign s_axi_awready_out = !aw_full;
	assign s_axi_wready_out = !w_full;
	assign wr_fire = aw_full && w_full && !s_axi_bvalid_out;
	// only a full low half-word while idle starts an instruction
	assign start = wr_fire && (aw_addr == pio_pkg::REG_INSTR)
		&& (w_strb[1:0] == 2'h3) && (state == pio_pkg::S_IDLE);

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			aw_full <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid_in && !aw_full) begin
			aw_full <= 1'b1;
			aw_addr <= s_axi_awaddr_in;
		end else if (wr_fire) begin
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			w_full <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid_in && !w_full) begin
			w_full <= 1'b1;
			w_data <= s_axi_wdata_in;
			w_strb <= s_axi_wstrb_in;
		end else if (wr_fire) begin
			w_full <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= pio_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_out <= 1'b1;
			case (aw_addr)
				pio_pkg::REG_INSTR,
				pio_pkg::REG_ACC,
				pio_pkg::REG_LIGHTS: s_axi_bresp_out <= pio_pkg::RESP_OKAY;
				default: s_axi_bresp_out <= pio_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	// ==========================================================
	// axi4-lite read path
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_err = 1'b0;
		case (s_axi_araddr_in)
			pio_pkg::REG_INSTR: rd_word[15:0] = cur;
			pio_pkg::REG_ACC: rd_word[15:0] = acc;
			pio_pkg::REG_STATUS: begin
				rd_word[pio_pkg::ST_BUSY] = (state != pio_pkg::S_IDLE);
				rd_word[pio_pkg::ST_SKIP] = skip_flag;
				rd_word[pio_pkg::ST_ACTED] = acted_flag;
				rd_word[pio_pkg::ST_NOTIO] = notio_flag;
			end
			pio_pkg::REG_LIGHTS: rd_word[15:0] = panel_lights_out;
			pio_pkg::REG_SWITCH: rd_word[15:0] = s_switch;
			default: rd_err = 1'b1;
		endcase
	end

	assign s_axi_arready_out = !s_axi_rvalid_out;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= pio_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= rd_word;
			s_axi_rresp_out <= rd_err ? pio_pkg::RESP_SLVERR
				: pio_pkg::RESP_OKAY;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// ==========================================================
	// decision taken in the test cycle
	always_comb begin
		t_act = 1'b0;
		t_skip = 1'b0;
		case (cur.kind)
			pio_pkg::TYPE_OCP: begin
				t_act = s_present && !cur_is_panel;
			end
			pio_pkg::TYPE_SKS: begin
				t_skip = s_present && s_ready && !cur_is_panel;
			end
			pio_pkg::TYPE_INA: begin
				if (cur_is_panel) begin
					t_act = 1'b1;
				end else begin
					t_act = s_present && s_ready;
					t_skip = t_act;
				end
			end
			pio_pkg::TYPE_OTA: begin
				if (cur_is_panel) begin
					t_act = 1'b1;
				end else begin
					t_act = s_present && (!s_need || s_ready);
					t_skip = s_present && s_need && s_ready;
				end
			end
			default: begin
				t_act = 1'b0;
			end
		endcase
	end

	// panel work is done inside, never on the external bus
	assign t_pulse = t_act && !cur_is_panel
		&& (cur.kind != pio_pkg::TYPE_SKS);

	// ==========================================================
	// sequencer
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			state <= pio_pkg::S_IDLE;
			settle <= 3'h0;
		end else begin
			case (state)
				pio_pkg::S_IDLE: begin
					if (start && new_is_io) begin
						state <= pio_pkg::S_SEL;
						settle <= pio_pkg::SETTLE_CYCLES - 3'h1;
					end
				end
				pio_pkg::S_SEL: begin
					// answer must pass the synchronisers first
					if (settle == 3'h0) begin
						state <= pio_pkg::S_TEST;
					end else begin
						settle <= settle - 3'h1;
					end
				end
				pio_pkg::S_TEST: begin
					state <= t_pulse ? pio_pkg::S_PULSE : pio_pkg::S_IDLE;
				end
				pio_pkg::S_PULSE: begin
					state <= pio_pkg::S_IDLE;
				end
				default: begin
					state <= pio_pkg::S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			cur <= '0;
		end else if (start && new_is_io) begin
			cur <= wr_instr;
		end
	end

	// ==========================================================
	// result flags
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			skip_flag <= 1'b0;
			acted_flag <= 1'b0;
			notio_flag <= 1'b0;
		end else if (start) begin
			skip_flag <= 1'b0;
			acted_flag <= 1'b0;
			notio_flag <= !new_is_io;
		end else if (state == pio_pkg::S_TEST) begin
			skip_flag <= t_skip;
			acted_flag <= t_act;
		end
	end

	// ==========================================================
	// accumulator and panel lights
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			acc <= pio_pkg::ACC_RST;
		end else if (state == pio_pkg::S_TEST && t_act
			&& cur.kind == pio_pkg::TYPE_INA) begin
			// undriven lanes come in as zero
			acc <= cur_is_panel ? s_switch : (s_data & s_mask);
		end else if (wr_fire && aw_addr == pio_pkg::REG_ACC
			&& state == pio_pkg::S_IDLE) begin
			if (w_strb[0]) begin
				acc[7:0] <= w_data[7:0];
			end
			if (w_strb[1]) begin
				acc[15:8] <= w_data[15:8];
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			panel_lights_out <= pio_pkg::LIGHTS_RST;
		end else if (state == pio_pkg::S_TEST && cur_is_panel
			&& cur.kind == pio_pkg::TYPE_OTA) begin
			panel_lights_out <= acc;
		end else if (wr_fire && aw_addr == pio_pkg::REG_LIGHTS) begin
			if (w_strb[0]) begin
				panel_lights_out[7:0] <= w_data[7:0];
			end
			if (w_strb[1]) begin
				panel_lights_out[15:8] <= w_data[15:8];
			end
		end
	end

	// ==========================================================
	// i/o bus drive
	assign io_cmd_out = '{kind: cur.kind, func: cur.func, dev: cur.dev};
	assign io_select_out = (state != pio_pkg::S_IDLE) && !cur_is_panel;
	assign io_strobe_out = (state == pio_pkg::S_PULSE);
	assign io_data_out = acc;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);

	chk_non_io_ignored: assert property (
		(start && !new_is_io) |=> (state == pio_pkg::S_IDLE) && notio_flag
	) else $error("non i/o instruction started the bus");

	chk_cmd_fields: assert property (
		(start && new_is_io) |=> (io_cmd_out.func == $past(w_data[9:6]))
			&& (io_cmd_out.dev == $past(w_data[5:0]))
	) else $error("bus command fields do not match instruction");

	chk_panel_internal: assert property (
		(io_cmd_out.dev == pio_pkg::DEV_PANEL) |-> !io_select_out
			&& !io_strobe_out
	) else $error("panel code driven onto the external bus");

	chk_settle_time: assert property (
		(start && new_is_io) |=> !io_strobe_out [*4]
	) else $error("strobe came before the answer settled");

	chk_sks_skip: assert property (
		(state == pio_pkg::S_TEST && cur.kind == pio_pkg::TYPE_SKS)
			|=> (skip_flag == $past(s_present && s_ready && !cur_is_panel))
			&& !io_strobe_out
	) else $error("skip test result wrong");

	chk_ina_clears: assert property (
		(state == pio_pkg::S_TEST && cur.kind == pio_pkg::TYPE_INA
			&& !cur_is_panel && s_present && s_ready)
			|=> (acc == $past(s_data & s_mask)) && skip_flag
			&& io_strobe_out
	) else $error("input did not load masked data and skip");

	chk_fail_hold: assert property (
		(state == pio_pkg::S_TEST && cur.kind == pio_pkg::TYPE_INA
			&& !cur_is_panel && !s_ready)
			|=> $stable(acc) && !skip_flag && (state == pio_pkg::S_IDLE)
	) else $error("failed ready test changed state");

	chk_ota_no_test: assert property (
		(state == pio_pkg::S_TEST && cur.kind == pio_pkg::TYPE_OTA
			&& !cur_is_panel && s_present && !s_need)
			|=> !skip_flag && io_strobe_out
	) else $error("output without ready test misbehaved");

	chk_ota_acc_hold: assert property (
		(state != pio_pkg::S_IDLE && cur.kind == pio_pkg::TYPE_OTA)
			|=> $stable(acc)
	) else $error("output changed the accumulator");

	chk_panel_no_skip: assert property (
		(state == pio_pkg::S_TEST && cur_is_panel
			&& cur.kind == pio_pkg::TYPE_OTA)
			|=> !skip_flag && acted_flag && (panel_lights_out == $past(acc))
	) else $error("panel output skipped or lost data");

	chk_absent_noop: assert property (
		(state == pio_pkg::S_TEST && !cur_is_panel && !s_present)
			|=> !skip_flag && !acted_flag && !io_strobe_out && $stable(acc)
	) else $error("absent device had an effect");
endmodule : pio_engine

// file: verif/pio_dev_model.sv
// behavioural model of one peripheral controller on the i/o bus
`timescale 1ns/100ps
module pio_dev_model #(
	parameter logic [5:0] DEV = 6'h01,
	parameter logic [15:0] DEV_ID = 16'h0123, // arbitrary value
	parameter int DELAY = 60,
	parameter logic [15:0] SLOT = 16'h0003
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire pio_pkg::pio_bus_cmd_t cmd_in,
	input wire logic select_in,
	input wire logic strobe_in,
	input wire logic [15:0] acc_in,
	input wire logic [15:0] word_in,
	output logic present_out,
	output logic ready_out,
	output logic need_ready_out,
	output logic [15:0] data_out,
	output logic [15:0] mask_out,
	output logic [15:0] taken_out
);
	logic rdy, ie, tg, sup, rd, need, hit;
	logic [15:0] d, m;
	int cnt;
	// ==========================================================
	// answers: ready, need, data and mask toggle when not addressed (present stays low), so stale values never pass
	assign hit = select_in && cmd_in.dev == DEV;
	always_comb begin
		sup = 1'b1;
		rd = 1'b1;
		need = 1'b0;
		d = 16'h0000;
		m = 16'h0000;
		case ({cmd_in.kind, cmd_in.func})
		6'h00, 6'h0f, 6'h31: sup = 1'b1;
		6'h10: rd = rdy;
		6'h14: rd = rdy && ie;
		6'h20: begin
			rd = rdy;
			d = word_in;
			m = 16'h00ff;
		end
		6'h21: begin
			d = {14'h0000, ie, rdy};
			m = 16'h0003;
		end
		6'h22: begin
			d = DEV_ID;
			m = 16'hffff;
		end
		6'h23: begin
			d = {10'h000, DEV};
			m = 16'h003f;
		end
		6'h24: begin
			d = SLOT;
			m = 16'hffff;
		end
		6'h30: begin
			rd = rdy;
			need = 1'b1;
		end
		default: sup = 1'b0;
		endcase
	end
	assign present_out = hit && sup;
	assign ready_out = hit ? rd : tg;
	assign need_ready_out = hit ? need : tg;
	assign data_out = hit ? d : {16{tg}};
	assign mask_out = hit ? m : {16{tg}};
	// ==========================================================
	// flags
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			rdy <= 1'b0;
			ie <= 1'b0;
			tg <= 1'b0;
			cnt <= 0;
			taken_out <= 16'h0000;
		end else begin
			tg <= ~tg;
			if (cnt == 1) rdy <= 1'b1;
			if (cnt != 0) cnt <= cnt - 1;
			if (strobe_in && hit) begin
				case ({cmd_in.kind, cmd_in.func})
				6'h00, 6'h20: begin
					rdy <= 1'b0;
					cnt <= DELAY;
				end
				6'h30: begin
					rdy <= 1'b0;
					cnt <= DELAY;
					taken_out <= acc_in & 16'h00ff;
				end
				6'h0f: begin
					rdy <= 1'b1;
					cnt <= 0;
				end
				6'h31: ie <= acc_in[0];
				default: ;
				endcase
			end
		end
	end
endmodule : pio_dev_model

// file: verif/programmed_io_bus_interface_bench.sv
// self-checking bench for the programmed i/o engine
`timescale 1ns/100ps
module programmed_io_bus_interface_bench;
	localparam logic [15:0] WORD = 16'ha5c3;
	localparam logic [15:0] SW = 16'h3c5a;
	localparam logic [15:0] ID = 16'h0123;
	localparam logic [5:0] DV = 6'h01;
	localparam logic [15:0] SL = 16'h0007;
	localparam logic [5:0] PNL = 6'h10;
	localparam int SK = pio_pkg::ST_SKIP;
	localparam int AC = pio_pkg::ST_ACTED;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
	logic aw_valid = 1'b0, w_valid = 1'b0, ar_valid = 1'b0;
	logic [31:0] w_data = 32'h0, r_data;
	logic [3:0] w_strb = 4'hf;
	logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
	logic [1:0] b_resp, r_resp;
	pio_pkg::pio_bus_cmd_t cmd;
	logic sel, stb, pres, rdy, need;
	logic [15:0] dout, din, mask, taken, lights;
	int err_count = 0, checks = 0, sel20 = 0, strobes = 0;
	always #2 clk_sys_in = ~clk_sys_in;
	always @(negedge clk_sys_in) begin
		if (sel && cmd.dev == PNL) sel20++;
		if (stb) strobes++;
	end
	pio_engine i_pio_engine (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid),
		.s_axi_awready_out(aw_ready), .s_axi_wdata_in(w_data),
		.s_axi_wstrb_in(w_strb), .s_axi_wvalid_in(w_valid),
		.s_axi_wready_out(w_ready), .s_axi_bresp_out(b_resp),
		.s_axi_bvalid_out(b_valid), .s_axi_bready_in(1'b1),
		.s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid),
		.s_axi_arready_out(ar_ready), .s_axi_rdata_out(r_data),
		.s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_valid),
		.s_axi_rready_in(1'b1), .io_cmd_out(cmd), .io_select_out(sel),
		.io_strobe_out(stb), .io_data_out(dout), .io_present_in(pres),
		.io_ready_in(rdy), .io_need_ready_in(need), .io_data_in(din),
		.io_data_mask_in(mask), .panel_switch_in(SW),
		.panel_lights_out(lights)
	);
	pio_dev_model #(.DEV(DV), .DEV_ID(ID), .DELAY(60), .SLOT(SL))
		i_pio_dev_model (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .cmd_in(cmd),
		.select_in(sel), .strobe_in(stb), .acc_in(dout), .word_in(WORD),
		.present_out(pres), .ready_out(rdy), .need_ready_out(need),
		.data_out(din), .mask_out(mask), .taken_out(taken)
	);
	// ==========================================================
	// shared tasks
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		checks++;
		if (seen !== ex) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, ex, seen);
		end
	endtask : chk
	task report_and_stop;
		$display("mismatches %0d comparisons %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop
	task give_up;
		err_count++;
		report_and_stop();
	endtask : give_up
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		int n;
		aw_addr <= a;
		aw_valid <= 1'b1;
		w_data <= d;
		w_valid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk_sys_in);
			ta = aw_valid && aw_ready;
			tw = w_valid && w_ready;
			tb = b_valid;
			r = b_resp;
			@(posedge clk_sys_in);
			if (ta) aw_valid <= 1'b0;
			if (tw) w_valid <= 1'b0;
			if (tb) break;
		end
		if (n == 50) give_up();
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		int n;
		ar_addr <= a;
		ar_valid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk_sys_in);
			ta = ar_valid && ar_ready;
			tr = r_valid;
			d = r_data;
			r = r_resp;
			@(posedge clk_sys_in);
			if (ta) ar_valid <= 1'b0;
			if (tr) break;
		end
		if (n == 50) give_up();
	endtask : rd
	function automatic logic [15:0] ins(logic [1:0] k, logic [3:0] f,
		logic [5:0] d);
		return {k, 4'hc, f, d};
	endfunction : ins
	task run(input logic [15:0] i, output logic [3:0] st);
		logic [31:0] v;
		logic [1:0] r;
		int n;
		wr(pio_pkg::REG_INSTR, {16'h0000, i}, r);
		for (n = 0; n < 20; n++) begin
			rd(pio_pkg::REG_STATUS, v, r);
			if (v[pio_pkg::ST_BUSY] === 1'b0) break;
		end
		if (n == 20) give_up();
		st = v[3:0];
	endtask : run
	task acc_is(input logic [15:0] ex, input string nm);
		logic [31:0] v;
		logic [1:0] r;
		rd(pio_pkg::REG_ACC, v, r);
		chk(nm, v, {16'h0000, ex});
	endtask : acc_is
	task wait_ready;
		logic [3:0] st;
		int n;
		for (n = 0; n < 20; n++) begin
			run(ins(2'h1, 4'h0, DV), st);
			if (st[SK] === 1'b1) break;
		end
		if (n == 20) give_up();
	endtask : wait_ready
	// ==========================================================
	// scenarios
	task t_regs;
		logic [31:0] v;
		logic [1:0] r;
		acc_is(16'h0000, "acc_reset");
		rd(pio_pkg::REG_SWITCH, v, r);
		chk("switch", v, {16'h0000, SW});
		rd(8'h14, v, r);
		chk("unmapped_rd", {r, v[29:0]}, {pio_pkg::RESP_SLVERR, 30'h0});
		wr(8'h14, 32'h1, r);
		chk("unmapped_wr", r, pio_pkg::RESP_SLVERR);
	endtask : t_regs
	task t_ctl;
		logic [3:0] st;
		logic [1:0] r;
		int s;
		// a single-byte instruction write must not start anything
		w_strb <= 4'h1;
		wr(pio_pkg::REG_INSTR, {16'h0000, ins(2'h0, 4'hf, DV)}, r);
		w_strb <= 4'hf;
		run(ins(2'h1, 4'h0, DV), st);
		chk("half_instr", st[SK], 1'b0);
		run(ins(2'h0, 4'hf, DV), st);
		chk("ocp_init", st[AC], 1'b1);
		s = strobes;
		run(ins(2'h1, 4'h0, DV), st);
		chk("sks_ready", st[SK], 1'b1);
		chk("sks_strobe", strobes, s);
		run(ins(2'h0, 4'h0, DV), st);
		run(ins(2'h1, 4'h0, DV), st);
		chk("sks_started", st[SK], 1'b0);
	endtask : t_ctl
	task t_ina;
		logic [3:0] st;
		logic [1:0] r;
		wr(pio_pkg::REG_ACC, 32'h0000ffff, r);
		wait_ready();
		run(ins(2'h2, 4'h0, DV), st);
		chk("ina_skip", st[SK], 1'b1);
		acc_is(WORD & 16'h00ff, "ina_acc");
		run(ins(2'h2, 4'h0, DV), st);
		chk("ina_again", st[SK], 1'b0);
		acc_is(WORD & 16'h00ff, "ina_kept");
		run(ins(2'h2, 4'h2, DV), st);
		acc_is(ID, "ina_ident");
		run(ins(2'h2, 4'h1, DV), st);
		chk("ina_status", st[SK], 1'b1);
		acc_is(16'h0000, "ina_status_acc");
		run(ins(2'h2, 4'h3, DV), st);
		acc_is({10'h000, DV}, "ina_code");
		run(ins(2'h2, 4'h4, DV), st);
		acc_is(SL, "ina_slot");
	endtask : t_ina
	task t_ota;
		logic [3:0] st;
		logic [1:0] r;
		wait_ready();
		wr(pio_pkg::REG_ACC, 32'h00005a5b, r);
		run(ins(2'h3, 4'h0, DV), st);
		chk("ota_skip", st[SK], 1'b1);
		chk("ota_taken", taken, 16'h005b);
		chk("ota_data", dout, 16'h5a5b);
		acc_is(16'h5a5b, "ota_acc");
		run(ins(2'h3, 4'h0, DV), st);
		chk("ota_busy", st[AC:SK], 2'b00);
		run(ins(2'h3, 4'h1, DV), st);
		chk("ota_noready", st[AC:SK], 2'b10);
		wait_ready();
		run(ins(2'h1, 4'h4, DV), st);
		chk("sks_irq", st[SK], 1'b1);
		wr(pio_pkg::REG_ACC, 32'h0, r);
		run(ins(2'h3, 4'h1, DV), st);
		run(ins(2'h1, 4'h4, DV), st);
		chk("sks_irq_off", st[SK], 1'b0);
	endtask : t_ota
	task t_panel;
		logic [3:0] st;
		logic [31:0] v;
		logic [1:0] r;
		wr(pio_pkg::REG_ACC, 32'h0000beef, r);
		run(ins(2'h3, 4'hf, PNL), st);
		chk("lights_skip", st[SK], 1'b0);
		chk("lights_pin", lights, 16'hbeef);
		rd(pio_pkg::REG_LIGHTS, v, r);
		chk("lights", v, 32'h0000beef);
		run(ins(2'h2, 4'hf, PNL), st);
		chk("switch_skip", st[SK], 1'b0);
		acc_is(SW, "switch_acc");
		chk("panel_select", sel20, 0);
	endtask : t_panel
	task t_none;
		logic [3:0] st;
		logic [1:0] r;
		int s;
		wr(pio_pkg::REG_ACC, 32'h00001234, r);
		s = strobes;
		run(ins(2'h2, 4'h0, 6'h05), st);
		chk("absent", st[AC:SK], 2'b00);
		run(ins(2'h0, 4'h3, DV), st);
		chk("bad_func", st[AC:SK], 2'b00);
		chk("no_strobe", strobes, s);
		run({2'h2, 4'h5, 10'h000}, st);
		chk("not_io", st[pio_pkg::ST_NOTIO], 1'b1);
		acc_is(16'h1234, "acc_kept");
	endtask : t_none
	// ==========================================================
	// main sequence
	initial begin
		repeat (20) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		t_regs();
		t_ctl();
		t_ina();
		t_ota();
		t_panel();
		t_none();
		report_and_stop();
	end
endmodule : programmed_io_bus_interface_bench
